// ---- rtl/left_hp_route_regs.vh ----
// register map constants for the left headphone routing and volume bank
// assumes a 25 MHz control clock and a 7-bit page-0 register address
`ifndef LEFT_HP_ROUTE_REGS_VH
`define LEFT_HP_ROUTE_REGS_VH

// register addresses
`define ADDR_LEFT_DAC_TO_MAIN      7'h2F
`define ADDR_RIGHT_LINE2_TO_MAIN   7'h30
`define ADDR_RIGHT_AMP_TO_MAIN     7'h31
`define ADDR_RIGHT_DAC_TO_MAIN     7'h32
`define ADDR_MAIN_LEVEL_CONTROL    7'h33
`define ADDR_LEFT_LINE2_TO_COMMON  7'h34
`define ADDR_LEFT_AMP_TO_COMMON    7'h35
`define ADDR_LEFT_DAC_TO_COMMON    7'h36
`define ADDR_RIGHT_LINE2_TO_COMMON 7'h37
`define ADDR_RIGHT_AMP_TO_COMMON   7'h38
`define ADDR_RIGHT_DAC_TO_COMMON   7'h39

// channel counts
`define MAIN_PATHS                 4
`define COMMON_PATHS               6
`define ALL_PATHS                  10

// channel slots, main driver paths first
`define SLOT_LEFT_DAC_TO_MAIN      0
`define SLOT_RIGHT_LINE2_TO_MAIN   1
`define SLOT_RIGHT_AMP_TO_MAIN     2
`define SLOT_RIGHT_DAC_TO_MAIN     3
`define SLOT_LEFT_LINE2_TO_COMMON  4
`define SLOT_LEFT_AMP_TO_COMMON    5
`define SLOT_LEFT_DAC_TO_COMMON    6
`define SLOT_RIGHT_LINE2_TO_COMMON 7
`define SLOT_RIGHT_AMP_TO_COMMON   8
`define SLOT_RIGHT_DAC_TO_COMMON   9

// routing register fields
`define ROUTE_ENABLE_BIT           7
`define ROUTE_VOLUME_MSB           6
`define ROUTE_RESET                8'h00
`define VOLUME_MUTE_FIRST          7'h76

// level control register fields
`define LEVEL_MSB                  7
`define LEVEL_LSB                  4
`define UNMUTE_BIT                 3
`define PD_HIZ_BIT                 2
`define PENDING_BIT                1
`define POWER_BIT                  0
`define LEVEL_RESET                4'h0
`define UNMUTE_RESET               1'b0
`define PD_HIZ_RESET               1'b1
`define POWER_RESET                1'b0

// unmapped reads
`define READ_UNMAPPED              8'h00

// gain ramp timing
`define CLOCK_PERIOD_NS            40
`define STEP_TIME_NS               1000
`define STEP_CYCLES                ((`STEP_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define STEP_COUNT_W               8

`endif

// ---- rtl/route_path_channel.v ----
// one source-to-driver routing register with its gain ramp
// assumes write strobes and the step pulse come from logic on the same clock
`include "left_hp_route_regs.vh"

module route_path_channel (
  input  wire       clock,
  input  wire       rst_b,
  input  wire       write_en,
  input  wire [7:0] write_data,
  input  wire       step,
  output reg  [7:0] reg_value,
  output reg  [6:0] applied_volume,
  output reg        route_enable,
  output reg        path_muted,
  output reg        gain_pending
);

  wire [6:0] target_volume;
  reg  [6:0] next_applied;

  assign target_volume = reg_value[`ROUTE_VOLUME_MSB:0];

  // applied code walks one step per tick toward the programmed code
  always @* begin
    next_applied = applied_volume;
    if (step && (applied_volume < target_volume)) begin
      next_applied = applied_volume + 7'h01;
    end else if (step && (applied_volume > target_volume)) begin
      next_applied = applied_volume - 7'h01;
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_value      <= `ROUTE_RESET;
      applied_volume <= 7'h00;
      route_enable   <= 1'b0;
      path_muted     <= 1'b1;
      gain_pending   <= 1'b0;
    end else begin
      if (write_en) begin
        reg_value <= write_data;
      end
      applied_volume <= next_applied;
      route_enable   <= reg_value[`ROUTE_ENABLE_BIT];
      path_muted     <= !reg_value[`ROUTE_ENABLE_BIT] ||
                        (next_applied >= `VOLUME_MUTE_FIRST);
      gain_pending   <= (next_applied != target_volume);
    end
  end

endmodule // route_path_channel

// ---- rtl/left_headphone_route_volume_regs.v ----
// page-0 register bank for the main and common left headphone drivers
// assumes the serial control port decodes frames into one-cycle strobes
// on this clock, and drives page_zero_selected from its page register
`include "left_hp_route_regs.vh"

module left_headphone_route_volume_regs (
  input  wire        clock,
  input  wire        rst_b,
  input  wire        page_zero_selected,
  input  wire        reg_write,
  input  wire        reg_read,
  input  wire [6:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output reg         reg_rvalid,
  output wire [3:0]  main_route_enable,
  output wire [27:0] main_path_volume,
  output wire [3:0]  main_path_muted,
  output wire [5:0]  common_route_enable,
  output wire [41:0] common_path_volume,
  output wire [5:0]  common_path_muted,
  output reg  [3:0]  main_level,
  output reg         main_unmute,
  output reg         main_pd_hiz,
  output reg         main_power_up,
  output reg         main_gain_pending
);

  wire [31:0]              step_last_full;
  wire [`STEP_COUNT_W-1:0] step_last;
  reg  [`STEP_COUNT_W-1:0] step_count;
  reg                      step;

  wire [7:0]  chan_value  [0:`ALL_PATHS-1];
  wire [6:0]  chan_volume [0:`ALL_PATHS-1];
  wire [`ALL_PATHS-1:0] chan_write;
  wire [`ALL_PATHS-1:0] chan_route;
  wire [`ALL_PATHS-1:0] chan_muted;
  wire [`ALL_PATHS-1:0] chan_pending;
  reg  [`ALL_PATHS-1:0] path_select;
  reg                   level_select;

  wire        bank_write;
  wire        bank_read;
  wire        level_write;
  reg  [7:0]  next_rdata;

  assign bank_write     = reg_write && page_zero_selected;
  assign bank_read      = reg_read && page_zero_selected;
  assign level_write    = bank_write && level_select;
  // tick period minus one, cut to the counter width on purpose
  assign step_last_full = `STEP_CYCLES - 1;
  assign step_last      = step_last_full[`STEP_COUNT_W-1:0];

  // address decode: one select per routing register, one for the level register
  always @* begin
    path_select  = {`ALL_PATHS{1'b0}};
    level_select = 1'b0;
    case (reg_addr)
      `ADDR_LEFT_DAC_TO_MAIN: begin
        path_select[`SLOT_LEFT_DAC_TO_MAIN] = 1'b1;
      end
      `ADDR_RIGHT_LINE2_TO_MAIN: begin
        path_select[`SLOT_RIGHT_LINE2_TO_MAIN] = 1'b1;
      end
      `ADDR_RIGHT_AMP_TO_MAIN: begin
        path_select[`SLOT_RIGHT_AMP_TO_MAIN] = 1'b1;
      end
      `ADDR_RIGHT_DAC_TO_MAIN: begin
        path_select[`SLOT_RIGHT_DAC_TO_MAIN] = 1'b1;
      end
      `ADDR_MAIN_LEVEL_CONTROL: begin
        level_select = 1'b1;
      end
      `ADDR_LEFT_LINE2_TO_COMMON: begin
        path_select[`SLOT_LEFT_LINE2_TO_COMMON] = 1'b1;
      end
      `ADDR_LEFT_AMP_TO_COMMON: begin
        path_select[`SLOT_LEFT_AMP_TO_COMMON] = 1'b1;
      end
      `ADDR_LEFT_DAC_TO_COMMON: begin
        path_select[`SLOT_LEFT_DAC_TO_COMMON] = 1'b1;
      end
      `ADDR_RIGHT_LINE2_TO_COMMON: begin
        path_select[`SLOT_RIGHT_LINE2_TO_COMMON] = 1'b1;
      end
      `ADDR_RIGHT_AMP_TO_COMMON: begin
        path_select[`SLOT_RIGHT_AMP_TO_COMMON] = 1'b1;
      end
      `ADDR_RIGHT_DAC_TO_COMMON: begin
        path_select[`SLOT_RIGHT_DAC_TO_COMMON] = 1'b1;
      end
      default: begin
        path_select  = {`ALL_PATHS{1'b0}};
        level_select = 1'b0;
      end
    endcase
  end

  // ramp tick shared by all paths
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      step_count <= {`STEP_COUNT_W{1'b0}};
      step       <= 1'b0;
    end else begin
      if (step_count == step_last) begin
        step_count <= {`STEP_COUNT_W{1'b0}};
        step       <= 1'b1;
      end else begin
        step_count <= step_count + {{(`STEP_COUNT_W-1){1'b0}}, 1'b1};
        step       <= 1'b0;
      end
    end
  end

  // channels 0..3 feed the main driver, 4..9 the common driver
  genvar i;
  generate
    for (i = 0; i < `ALL_PATHS; i = i + 1) begin : g_path
      if (i < `MAIN_PATHS) begin : g_main
        assign main_route_enable[i]       = chan_route[i];
        assign main_path_muted[i]         = chan_muted[i];
        assign main_path_volume[7*i +: 7] = chan_volume[i];
      end else begin : g_common
        assign common_route_enable[i-`MAIN_PATHS]       = chan_route[i];
        assign common_path_muted[i-`MAIN_PATHS]         = chan_muted[i];
        assign common_path_volume[7*(i-`MAIN_PATHS) +: 7] = chan_volume[i];
      end

      assign chan_write[i] = bank_write && path_select[i];

      route_path_channel u_path (
        .clock          (clock),
        .rst_b          (rst_b),
        .write_en       (chan_write[i]),
        .write_data     (reg_wdata),
        .step           (step),
        .reg_value      (chan_value[i]),
        .applied_volume (chan_volume[i]),
        .route_enable   (chan_route[i]),
        .path_muted     (chan_muted[i]),
        .gain_pending   (chan_pending[i])
      );
    end
  endgenerate

  // main driver level, mute, powerdown drive and power
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      main_level    <= `LEVEL_RESET;
      main_unmute   <= `UNMUTE_RESET;
      main_pd_hiz   <= `PD_HIZ_RESET;
      main_power_up <= `POWER_RESET;
    end else if (level_write) begin
      main_level    <= reg_wdata[`LEVEL_MSB:`LEVEL_LSB];
      main_unmute   <= reg_wdata[`UNMUTE_BIT];
      main_pd_hiz   <= reg_wdata[`PD_HIZ_BIT];
      main_power_up <= reg_wdata[`POWER_BIT];
    end
  end

  // pending while any path into the main driver is still ramping
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      main_gain_pending <= 1'b0;
    end else begin
      main_gain_pending <= |chan_pending[`MAIN_PATHS-1:0];
    end
  end

  // read multiplexer; unmapped addresses read as zero
  always @* begin
    next_rdata = `READ_UNMAPPED;
    case (reg_addr)
      `ADDR_LEFT_DAC_TO_MAIN: begin
        next_rdata = chan_value[`SLOT_LEFT_DAC_TO_MAIN];
      end
      `ADDR_RIGHT_LINE2_TO_MAIN: begin
        next_rdata = chan_value[`SLOT_RIGHT_LINE2_TO_MAIN];
      end
      `ADDR_RIGHT_AMP_TO_MAIN: begin
        next_rdata = chan_value[`SLOT_RIGHT_AMP_TO_MAIN];
      end
      `ADDR_RIGHT_DAC_TO_MAIN: begin
        next_rdata = chan_value[`SLOT_RIGHT_DAC_TO_MAIN];
      end
      `ADDR_MAIN_LEVEL_CONTROL: begin
        next_rdata = {main_level, main_unmute, main_pd_hiz,
                      main_gain_pending, main_power_up};
      end
      `ADDR_LEFT_LINE2_TO_COMMON: begin
        next_rdata = chan_value[`SLOT_LEFT_LINE2_TO_COMMON];
      end
      `ADDR_LEFT_AMP_TO_COMMON: begin
        next_rdata = chan_value[`SLOT_LEFT_AMP_TO_COMMON];
      end
      `ADDR_LEFT_DAC_TO_COMMON: begin
        next_rdata = chan_value[`SLOT_LEFT_DAC_TO_COMMON];
      end
      `ADDR_RIGHT_LINE2_TO_COMMON: begin
        next_rdata = chan_value[`SLOT_RIGHT_LINE2_TO_COMMON];
      end
      `ADDR_RIGHT_AMP_TO_COMMON: begin
        next_rdata = chan_value[`SLOT_RIGHT_AMP_TO_COMMON];
      end
      `ADDR_RIGHT_DAC_TO_COMMON: begin
        next_rdata = chan_value[`SLOT_RIGHT_DAC_TO_COMMON];
      end
      default: begin
        next_rdata = `READ_UNMAPPED;
      end
    endcase
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata  <= `READ_UNMAPPED;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= bank_read;
      if (bank_read) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule // left_headphone_route_volume_regs

// ---- sim/route_regs_chk.sv ----
// port assertions for the left headphone routing register bank
// assumes it is bound onto the bank's top module
module route_regs_chk (
  input logic       clock,
  input logic       rst_b,
  input logic       page_zero_selected,
  input logic       reg_write,
  input logic       reg_read,
  input logic [6:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  input logic       reg_rvalid,
  input logic [3:0] main_route_enable,
  input logic [3:0] main_level,
  input logic       main_unmute,
  input logic       main_pd_hiz,
  input logic       main_power_up
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire rd = reg_read && page_zero_selected;
  wire lv = reg_write && page_zero_selected && reg_addr == 7'h33;
  read_answer_a: assert property (rd |=> reg_rvalid) else $error("read unanswered");
  answer_cause_a: assert property (reg_rvalid |-> $past(rd)) else $error("stray answer");
  unmapped_zero_a: assert property (rd && (reg_addr < 7'h2F || reg_addr > 7'h39)
    |=> reg_rdata == 8'h00) else $error("unmapped read");
  route_enable_a: assert property (reg_write && page_zero_selected && reg_addr == 7'h2F
    |=> ##1 main_route_enable[0] == $past(reg_wdata[7], 2)) else $error("route enable");
  level_field_a: assert property (lv |=> main_level == $past(reg_wdata[7:4])) else $error("level");
  unmute_bit_a: assert property (lv |=> main_unmute == $past(reg_wdata[3])) else $error("mute");
  pd_drive_a: assert property (lv |=> main_pd_hiz == $past(reg_wdata[2])) else $error("pd");
  power_bit_a: assert property (lv |=> main_power_up == $past(reg_wdata[0])) else $error("pwr");
endmodule // route_regs_chk

bind left_headphone_route_volume_regs route_regs_chk u_chk (.clock, .rst_b,
  .page_zero_selected, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
  .reg_rvalid, .main_route_enable, .main_level, .main_unmute, .main_pd_hiz, .main_power_up);

// ---- sim/left_headphone_route_volume_regs_bench.sv ----
// self-checking bench for the left headphone routing register bank
// assumes the bank and its checker are compiled ahead of this file
module left_headphone_route_volume_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, rst_b, page_zero_selected, reg_write, reg_read;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, d, q;
  logic [7:0]  wrote [0:10];
  logic [31:0] seed;
  wire  [7:0]  reg_rdata;
  wire         reg_rvalid, main_unmute, main_pd_hiz, main_power_up, main_gain_pending;
  wire  [3:0]  main_route_enable, main_path_muted, main_level;
  wire  [5:0]  common_route_enable, common_path_muted;
  wire  [41:0] common_path_volume;
  wire  [27:0] main_path_volume;
  int          err_count, comparisons;
  left_headphone_route_volume_regs u_dut (.clock, .rst_b, .page_zero_selected, .reg_write,
    .reg_read, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .main_route_enable,
    .main_path_volume, .main_path_muted, .common_route_enable, .common_path_volume,
    .common_path_muted, .main_level, .main_unmute, .main_pd_hiz, .main_power_up,
    .main_gain_pending);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] exp_level(input logic [7:0] w);
    return {w[7:2], 1'b0, w[0]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] w);
    reg_addr = a;
    reg_wdata = w;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    @(negedge clock);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] r);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    check({7'h00, reg_rvalid}, 8'h01);
    r = reg_rdata;
    @(negedge clock);
  endtask
  // waits out the gain ramp of the main paths
  task automatic settle;
    repeat (4) @(negedge clock);
    for (int i = 0; i < 5000 && main_gain_pending !== 1'b0; i++) @(negedge clock);
    if (main_gain_pending !== 1'b0) begin
      err_count++;
      summarize();
    end
    repeat (4) @(negedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    {rst_b, reg_write, reg_read, reg_addr, reg_wdata} = '0;
    page_zero_selected = 1'b1;
    seed = 32'h00013893;
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    for (int a = 'h2F; a <= 'h39; a++) begin
      rd(a[6:0], q);
      check(q, a == 'h33 ? 8'h04 : 8'h00);
    end
    $display("test 1 done");
    for (int a = 'h2F; a <= 'h39; a++) begin
      seed = lfsr(seed);
      d = seed[7:0];
      if (a == 'h33) continue;
      wrote[a-'h2F] = d;
      wr(a[6:0], d);
      check(a < 'h33 ? main_route_enable[a-'h2F] : common_route_enable[a-'h34], d[7]);
      rd(a[6:0], q);
      check(q, d);
    end
    settle();
    // common paths are not covered by the status bit: give them a full ramp
    repeat (3300) @(negedge clock);
    for (int j = 0; j < 10; j++) begin
      d = wrote[j < 4 ? j : j + 1];
      if (j < 4) begin
        check({1'b0, main_path_volume[7*j +: 7]}, {1'b0, d[6:0]});
        check(main_path_muted[j], !d[7] || d[6:0] >= 7'h76);
      end else begin
        check({1'b0, common_path_volume[7*(j-4) +: 7]}, {1'b0, d[6:0]});
        check(common_path_muted[j-4], !d[7] || d[6:0] >= 7'h76);
      end
    end
    $display("test 2 done");
    for (int k = 0; k < 10; k++) begin
      seed = lfsr(seed);
      d = {k[3:0], seed[3:0]} | 8'h02;
      wr(7'h33, d);
      check({main_level, main_unmute, main_pd_hiz, 1'b0, main_power_up}, exp_level(d));
      rd(7'h33, q);
      check(q, exp_level(d));
    end
    $display("test 3 done");
    wr(7'h2F, 8'h80);
    settle();
    wr(7'h2F, 8'hF6);
    repeat (4) @(negedge clock);
    check(main_gain_pending, 1'b1);
    for (int i = 0; i < 4; i++) begin
      d = i == 0 ? 8'hF6 : i == 1 ? 8'hF5 : i == 2 ? 8'h05 : 8'hFF;
      wr(7'h2F, d);
      settle();
      check(main_path_volume[6:0], d[6:0]);
      check(main_path_muted[0], !d[7] || d[6:0] >= 7'h76);
    end
    $display("test 4 done");
    rd(7'h2E, q);
    check(q, 8'h00);
    rd(7'h3A, q);
    check(q, 8'h00);
    wr(7'h34, 8'h11);
    page_zero_selected = 1'b0;
    wr(7'h34, 8'hEE);
    page_zero_selected = 1'b1;
    rd(7'h34, q);
    check(q, 8'h11);
    $display("test 5 done");
    rst_b = 1'b0;
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    check({main_level, main_unmute, main_pd_hiz, 1'b0, main_power_up}, 8'h04);
    check({4'h0, main_route_enable}, 8'h00);
    check({4'h0, main_path_muted}, 8'h0F);
    rd(7'h34, q);
    check(q, 8'h00);
    $display("test 6 done");
    summarize();
  end
endmodule // left_headphone_route_volume_regs_bench
